// file: rtl/serial_adc_readout_control.sv
`default_nettype none

module serial_adc_readout_control
    import adc_readout_pkg::*;
(
    // Clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                nrst_i,
    // Host pins
    input  wire logic                ncs_i,
    input  wire logic                sclk_i,
    output logic                     sdo_o,
    output logic                     sdo_oe_n_o,
    // Analog front end
    input  wire logic                cmp_i,
    output logic [RESULT_W-1:0]      dac_code_o,
    output logic                     track_o,
    output logic                     conv_busy_o
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    ////////////////////////////////////////////////////////////////////

    logic [2:0] async_in;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    host_pins_s pins;
    logic       cmp_s;

    assign async_in = {cmp_i, ncs_i, sclk_i};

    // Two flops per pin; first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    sync1_q[gi] <= (gi == 1);
                    sync2_q[gi] <= (gi == 1);
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign pins  = '{ncs: sync2_q[1], sclk: sync2_q[0]};
    assign cmp_s = sync2_q[2];

    ////////////////////////////////////////////////////////////////////
    // Internal conversion clock: rise and fall enables from a divider
    ////////////////////////////////////////////////////////////////////

    logic [4:0] div_q;
    logic       int_rise;
    logic       int_fall;

    // Free-running, independent of any host activity
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= 5'h00;
        end else if (div_q == 5'(DIV_CYCLES - 1)) begin
            div_q <= 5'h00;
        end else begin
            div_q <= div_q + 5'h01;
        end
    end

    assign int_rise = (div_q == 5'h00);
    assign int_fall = (div_q == 5'(DIV_FALL_AT));

    ////////////////////////////////////////////////////////////////////
    // Chip select qualification
    ////////////////////////////////////////////////////////////////////

    logic       cs_low_q;
    logic       cs_fell;
    logic [1:0] rises_q;
    logic       fall_seen_q;
    logic       cs_pending;

    // Synchronised level differs from the accepted one
    assign cs_pending = (pins.ncs == cs_low_q);

    // A glitch that returns before the wait ends restarts the wait,
    // trading a little latency for immunity to noise on the select
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_low_q    <= 1'b0;
            rises_q     <= 2'h0;
            fall_seen_q <= 1'b0;
        end else if (!cs_pending) begin
            rises_q     <= 2'h0;
            fall_seen_q <= 1'b0;
        end else if (rises_q >= 2'(CS_RISES_NEEDED) &&
                     fall_seen_q) begin
            cs_low_q    <= !pins.ncs;
            rises_q     <= 2'h0;
            fall_seen_q <= 1'b0;
        end else begin
            if (int_rise && rises_q < 2'(CS_RISES_NEEDED)) begin
                rises_q <= rises_q + 2'h1;
            end
            if (int_fall && rises_q != 2'h0) begin
                fall_seen_q <= 1'b1;
            end
        end
    end

    assign cs_fell = cs_pending && !pins.ncs && fall_seen_q &&
                     rises_q >= 2'(CS_RISES_NEEDED);

    ////////////////////////////////////////////////////////////////////
    // Shift clock edges and serial output
    ////////////////////////////////////////////////////////////////////

    logic                sclk_prev_q;
    logic                sclk_fall;
    logic [3:0]          fall_cnt_q;
    logic [RESULT_W-1:0] shift_q;
    logic                start_conv;
    conv_status_s        status;

    // Shift clock edge detect on the synchronised level
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= pins.sclk;
        end
    end

    // Edges only count while select is accepted low and no change waits
    assign sclk_fall = sclk_prev_q && !pins.sclk && cs_low_q &&
                       !cs_pending;

    // Falling-edge count within one access; stops after the eighth
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fall_cnt_q <= 4'h0;
        end else if (cs_fell) begin
            fall_cnt_q <= 4'h0;
        end else if (sclk_fall && fall_cnt_q < 4'(SHIFT_CNT)) begin
            fall_cnt_q <= fall_cnt_q + 4'h1;
        end
    end

    // Load the previous result at select fall, shift on edges one to seven
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_q <= RESULT_RST;
        end else if (cs_fell) begin
            shift_q <= status.result;
        end else if (sclk_fall && fall_cnt_q < 4'(SHIFT_CNT - 1)) begin
            shift_q <= {shift_q[RESULT_W-2:0], 1'b0};
        end
    end

    // Eighth edge; a start while busy is dropped, the host must wait
    assign start_conv = sclk_fall && fall_cnt_q == 4'(SHIFT_CNT - 1) &&
                        !status.busy;

    // Pin drivers from flops; enable is low while driving
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdo_o      <= 1'b0;
            sdo_oe_n_o <= 1'b1;
        end else begin
            sdo_o      <= shift_q[RESULT_W-1];
            sdo_oe_n_o <= !cs_low_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Converter
    ////////////////////////////////////////////////////////////////////

    sar_engine u_sar (
        .ref_clk_i  (ref_clk_i),
        .nrst_i     (nrst_i),
        .tick_i     (int_rise),
        .start_i    (start_conv),
        .cmp_i      (cmp_s),
        .status_o   (status),
        .dac_code_o (dac_code_o),
        .track_o    (track_o)
    );

    assign conv_busy_o = status.busy;

endmodule : serial_adc_readout_control

`default_nettype wire

// file: rtl/adc_readout_pkg.sv
`default_nettype none

package adc_readout_pkg;

    // Data widths
    localparam int RESULT_W  = 8;
    localparam int SHIFT_CNT = 8;

    // Rates, all times in their own unit
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int INT_CLK_HZ = 4_000_000;
    localparam int DIV_CYCLES = SYS_CLK_HZ / INT_CLK_HZ;
    localparam int DIV_FALL_AT = DIV_CYCLES / 2;

    // Conversion timing in internal clock periods; the limit in ns and in system clock cycles
    localparam int CONV_PERIODS    = 36;
    localparam int SETTLE_PERIODS  = 4;
    localparam int PERIODS_PER_BIT = 4;
    localparam int CONV_MAX_NS     = 17_000;
    localparam int CONV_MAX_CYCLES =
        (CONV_MAX_NS / 1000) * (SYS_CLK_HZ / 1_000_000);

    // Chip select qualification: internal clock edges to wait
    localparam int CS_RISES_NEEDED = 2;
    localparam int CS_FALLS_NEEDED = 1;

    // Values after reset
    localparam logic [RESULT_W-1:0] RESULT_RST = 8'h00;

    // Converter state that travels from the engine to the port logic
    typedef struct packed {
        logic                busy;
        logic                done;
        logic [RESULT_W-1:0] result;
    } conv_status_s;

    // Host-side pins after synchronisation
    typedef struct packed {
        logic ncs;
        logic sclk;
    } host_pins_s;

endpackage : adc_readout_pkg

`default_nettype wire

// file: rtl/sar_engine.sv
`default_nettype none

module sar_engine
    import adc_readout_pkg::*;
(
    // Clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                nrst_i,
    // Control
    input  wire logic                tick_i,
    input  wire logic                start_i,
    input  wire logic                cmp_i,
    // Status and converter drive
    output conv_status_s             status_o,
    output logic [RESULT_W-1:0]      dac_code_o,
    output logic                     track_o
);

    typedef enum logic { SAR_IDLE, SAR_CONV } sar_state_e;

    sar_state_e          state_q;
    logic [5:0]          period_q;
    logic [RESULT_W-1:0] trial_q;
    logic [RESULT_W-1:0] result_q;
    logic                done_q;
    logic [5:0]          rel;
    logic [2:0]          bit_idx;
    logic [1:0]          phase;

    // Bit under trial and position inside its four periods
    assign rel     = period_q - 6'(SETTLE_PERIODS);
    assign bit_idx = 3'd7 - rel[4:2];
    assign phase   = rel[1:0];

    // Sequencer: settle on held sample, then one bit per four periods
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q  <= SAR_IDLE;
            period_q <= 6'h00;
        end else begin
            case (state_q)
                SAR_IDLE: begin
                    if (start_i) begin
                        state_q  <= SAR_CONV;
                        period_q <= 6'h00;
                    end
                end
                SAR_CONV: begin
                    if (tick_i) begin
                        if (period_q == 6'(CONV_PERIODS - 1)) begin
                            state_q <= SAR_IDLE;
                        end
                        period_q <= period_q + 6'h01;
                    end
                end
                default: state_q <= SAR_IDLE;
            endcase
        end
    end

    // Successive approximation; a comparator stuck high or low gives
    // all ones or all zeros, which is the saturation behaviour wanted
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trial_q <= 8'h00;
        end else if (start_i && state_q == SAR_IDLE) begin
            trial_q <= 8'h00;
        end else if (state_q == SAR_CONV && tick_i &&
                     period_q >= 6'(SETTLE_PERIODS)) begin
            if (phase == 2'h0) begin
                trial_q[bit_idx] <= 1'b1;
            end else if (phase == 2'h3 && !cmp_i) begin
                trial_q[bit_idx] <= 1'b0;
            end
        end
    end

    // Result latch and one-cycle done pulse
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            result_q <= RESULT_RST;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (state_q == SAR_CONV && tick_i &&
                period_q == 6'(CONV_PERIODS - 1)) begin
                result_q <= cmp_i ? trial_q
                                  : (trial_q & ~(8'h01));
                done_q   <= 1'b1;
            end
        end
    end

    assign status_o   = '{busy: (state_q == SAR_CONV), done: done_q,
                          result: result_q};
    assign dac_code_o = trial_q;
    assign track_o    = (state_q == SAR_IDLE);

endmodule : sar_engine

`default_nettype wire

// file: test/adc_readout_properties.sv
`default_nettype none

module adc_readout_properties
    import adc_readout_pkg::*;
(
    // Clock and reset
    input wire logic                ref_clk_i,
    input wire logic                nrst_i,
    // Host pins
    input wire logic                ncs_i,
    input wire logic                sclk_i,
    input wire logic                sdo_o,
    input wire logic                sdo_oe_n_o,
    // Analog front end
    input wire logic                cmp_i,
    input wire logic [RESULT_W-1:0] dac_code_o,
    input wire logic                track_o,
    input wire logic                conv_busy_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0]  hi_q;
    logic [7:0]  lo_q;
    logic [3:0]  falls_q;
    logic        sclk_q;
    logic        busy_q;
    logic [11:0] len_q;

    // Select run lengths; saturate so a long idle never wraps
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hi_q <= 8'h00;
            lo_q <= 8'h00;
        end else begin
            hi_q <= !ncs_i ? 8'h00 : hi_q + {7'h00, hi_q != 8'hFF};
            lo_q <= ncs_i ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
        end
    end

    // Raw pin falls; counted earlier than the design sees them
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_q  <= 1'b0;
            falls_q <= 4'h0;
        end else begin
            sclk_q  <= sclk_i;
            if (ncs_i) begin
                falls_q <= 4'h0;
            end else if (sclk_q && !sclk_i && falls_q != 4'hF) begin
                falls_q <= falls_q + 4'h1;
            end
        end
    end

    // Length of the last busy run, held after it ends
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_q <= 1'b0;
            len_q  <= 12'h000;
        end else begin
            busy_q <= conv_busy_o;
            if (conv_busy_o) begin
                len_q <= busy_q ? len_q + 12'h001 : 12'h001;
            end
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    float_idle_a: assert property (hi_q >= 8'h50 |-> sdo_oe_n_o)
        else $error("output driven while deselected");
    select_wait_a: assert property ($fell(sdo_oe_n_o) |-> lo_q >= 8'h1A)
        else $error("select accepted too early");
    select_bound_a: assert property (lo_q == 8'h50 |-> !sdo_oe_n_o)
        else $error("msb not driven after select");
    release_wait_a: assert property ($rose(sdo_oe_n_o) |-> hi_q >= 8'h1A)
        else $error("deselect accepted too early");
    eighth_start_a: assert property ($rose(conv_busy_o) |-> falls_q == 4'h8)
        else $error("conversion not started by eighth fall");
    busy_follow_a: assert property
        ($rose(falls_q == 4'h8) |-> ##[1:6] conv_busy_o)
        else $error("eighth fall did not start conversion");
    conv_len_a: assert property
        ($fell(conv_busy_o) |-> len_q inside {[12'h36B:12'h39D]})
        else $error("conversion length not 36 periods");
    hold_busy_a: assert property (conv_busy_o |-> !track_o)
        else $error("tracking during conversion");
    hold_start_a: assert property
        ($rose(falls_q == 4'h8) |-> ##[1:6] !track_o)
        else $error("sample not held at conversion start");
endmodule : adc_readout_properties

`default_nettype wire

// file: test/host_model.sv
`default_nettype none

module host_model (
    // Clock
    input  wire logic ref_clk_i,
    // Link pins
    output logic      ncs_o,
    output logic      sclk_o,
    input  wire logic sdo_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // Deselected, shift clock parked low between frames
    initial begin
        ncs_o  = 1'b1;
        sclk_o = 1'b0;
    end

    // One frame, then the full conversion time before the next one
    task automatic access(input int falls, output logic [7:0] got);
        got = 8'h00;
        @(posedge ref_clk_i);
        #1 ncs_o = 1'b0;
        #1400;
        for (int i = 0; i < falls; i++) begin
            sclk_o = 1'b1;
            #62.5; // Beyond the host limit on purpose, stresses capture
            got[7-i] = sdo_i; // Settled since the previous fall
            sclk_o = 1'b0;
            #62.5;
        end
        #62.5;
        ncs_o = 1'b1;
        #17000;
    endtask : access

    // Select pulled low too briefly to be accepted by the block
    task automatic blip(input int cyc);
        @(posedge ref_clk_i);
        #1 ncs_o = 1'b0;
        repeat (cyc) @(posedge ref_clk_i);
        #1 ncs_o = 1'b1;
        #1000;
    endtask : blip
endmodule : host_model

`default_nettype wire

// file: test/tb_serial_adc_readout_control.sv
`default_nettype none

module tb_serial_adc_readout_control;
    import adc_readout_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic                clk = 1'b0;
    logic                nrst = 1'b0;
    logic                ncs;
    logic                sclk;
    logic                cmp = 1'b0;
    logic                sdo;
    logic                sdo_oe_n;
    logic [RESULT_W-1:0] dac_code;
    logic                track;
    logic                conv_busy;
    wire                 sdo_pin;
    int                  level = 0;
    int                  busy_rises = 0;
    int                  oe_falls = 0;
    int                  fail_count = 0;
    int                  num_checks = 0;
    int                  corner[4] = '{256, -1, 0, 255};

    // Pin floats unless the block enables it
    assign sdo_pin = sdo_oe_n ? 1'bz : sdo;

    always #5 clk = ~clk;

    // Comparator: input sits half a code above level
    always @(posedge clk) begin
        #1 cmp <= (int'(dac_code) <= level);
    end

    always @(posedge conv_busy) begin
        busy_rises++;
    end

    // Each accepted select drives the pin once
    always @(negedge sdo_oe_n) begin
        oe_falls++;
    end

    serial_adc_readout_control serial_adc_readout_control_inst (
        .ref_clk_i(clk), .nrst_i(nrst), .ncs_i(ncs), .sclk_i(sclk),
        .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .cmp_i(cmp),
        .dac_code_o(dac_code), .track_o(track), .conv_busy_o(conv_busy)
    );

    host_model host_model_inst (
        .ref_clk_i(clk), .ncs_o(ncs), .sclk_o(sclk), .sdo_i(sdo_pin)
    );

    function automatic logic [7:0] exp_code(input int lvl);
        if (lvl < 0) return 8'h00;
        if (lvl > 255) return 8'hFF;
        return lvl[7:0];
    endfunction : exp_code

    task automatic check_val(input string what, input logic [7:0] exp,
                             input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // Short frames read only their top bits and must not convert
    task automatic frame(input int lvl, input int falls,
                         input logic [7:0] exp);
        logic [7:0] got;
        logic [7:0] mask;
        int         rises;
        rises = busy_rises;
        level = lvl;
        mask = 8'hFF << (8 - falls);
        host_model_inst.access(falls, got);
        check_val("result", exp & mask, got & mask);
        check_val("starts", 8'(falls == 8), 8'(busy_rises - rises));
        check_val("idle pin", {7'h00, 1'bz}, {7'h00, sdo_pin});
        check_val("tracking", 8'h01, {7'h00, track});
        check_val("busy", 8'h00, {7'h00, conv_busy});
        $display("frame level %0d falls %0d done", lvl, falls);
    endtask : frame

    // A select pulse shorter than the qualification wait is ignored
    task automatic glitch(input int cyc);
        int falls0;
        int rises0;
        falls0 = oe_falls;
        rises0 = busy_rises;
        host_model_inst.blip(cyc);
        check_val("glitch drive", 8'h00, 8'(oe_falls - falls0));
        check_val("glitch start", 8'h00, 8'(busy_rises - rises0));
        $display("glitch of %0d cycles done", cyc);
    endtask : glitch

    initial begin
        int         seed;
        logic [7:0] prev;
        int         lvl;
        seed = $urandom(32'h0EC0);
        prev = RESULT_RST;
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        for (int n = 0; n < 8; n++) begin
            lvl = (n < 4) ? corner[n] : int'($urandom_range(255, 0));
            frame(lvl, 8, prev);
            prev = exp_code(lvl);
        end
        frame(77, 3, prev);
        glitch(int'($urandom_range(20, 1)));
        frame(33, 8, prev);
        @(posedge clk);
        #1 nrst = 1'b0;
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        frame(140, 8, RESULT_RST);
        frame(12, 8, exp_code(140));
        conclude();
    end

    // About twelve frames of 20 us each; 400 us means a hang
    initial begin
        #400_000;
        fail_count++;
        $display("[ERR] watchdog expected end seen hang");
        conclude();
    end
endmodule : tb_serial_adc_readout_control

bind serial_adc_readout_control adc_readout_properties
    adc_readout_properties_inst (
    .ref_clk_i, .nrst_i, .ncs_i, .sclk_i, .sdo_o, .sdo_oe_n_o,
    .cmp_i, .dac_code_o, .track_o, .conv_busy_o
);

`default_nettype wire
